//--- rtl/dmag_addr_mux.v
// row/column multiplexer for one memory address bus
`timescale 1ns/1ps
module dmag_addr_mux
(
  input wire [7:0] rowAddr,
  input wire [7:0] colAddr,
  input wire colPhase,
  output wire [7:0] busOut
);
  // column phase selects column bits onto the bus
  assign busOut = colPhase ? colAddr : rowAddr;
endmodule // dmag_addr_mux

//--- rtl/dmag_display_memory_address_gen.v
// display memory address generator, refresh, split screen, cursor and vertical interrupt
`timescale 1ns/1ps
`include "dmag_regs.vh"
module dmag_display_memory_address_gen
(
  input wire clock,
  input wire reset,
  input wire [15:0] ioAddr,
  input wire [7:0] ioWrData,
  input wire ioWrite,
  input wire ioRead,
  output reg [7:0] ioRdData,
  input wire [7:0] emulation_mode_reg,
  input wire [7:0] miscOutput,
  input wire [7:0] seqIndex,
  input wire [7:0] hostModeCtrl,
  input wire hostReq,
  input wire [19:0] hostAddr,
  input wire chainMode,
  input wire [1:0] chain_select_code,
  input wire plane_page_bit,
  output reg hostAck,
  output reg hostRefused,
  input wire graphicsMode,
  input wire charClk,
  input wire hBlank,
  input wire screenStart,
  input wire lineStart,
  input wire [9:0] scanLine,
  input wire [7:0] char_code,
  input wire [1:0] font_select_code,
  input wire [15:0] startAddr,
  input wire [9:0] line_compare_reg,
  input wire [4:0] preset_row_scan_reg,
  input wire [4:0] max_scan_line_reg,
  input wire [7:0] row_offset_reg,
  input wire [4:0] cursor_start_reg,
  input wire [4:0] cursor_end_reg,
  input wire [7:0] cursor_loc_high,
  input wire [7:0] cursor_loc_low,
  input wire [7:0] vert_retrace_end_reg,
  input wire [9:0] vert_display_end_reg,
  output reg [7:0] mem_bus_a,
  output reg [7:0] mem_bus_b,
  output reg rowStrobe_n,
  output reg colStrobe_n,
  output reg cursorActive,
  output reg crt_interrupt_out,
  output reg [7:0] refreshRow,
  output reg [15:0] display_addr_counter,
  output reg [4:0] row_scan_count,
  output reg effPageSel
);
  // cycle states, one-hot
  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_ROW = 4'h2;
  localparam [3:0] ST_COL = 4'h4;
  localparam [3:0] ST_DONE = 4'h8;
  localparam [1:0] SRC_HOST = 2'h0;
  localparam [1:0] SRC_CRT = 2'h1;
  localparam [1:0] SRC_REF = 2'h2;

  reg [7:0] legacyCfg;
  reg [3:0] state;
  reg [1:0] src;
  reg [2:0] refreshDone;
  reg crtPending;
  reg [15:0] rowBase;
  reg [7:0] hostRowA;
  reg [7:0] hostRowB;
  reg [7:0] hostCol;
  reg [7:0] crtRowA;
  reg [7:0] crtRowB;
  reg [7:0] crtColA;
  reg [7:0] crtColB;
  reg [7:0] selRowA;
  reg [7:0] selRowB;
  reg [7:0] selColA;
  reg [7:0] selColB;
  reg hostInWindow;
  wire [7:0] muxA;
  wire [7:0] muxB;
  wire legacyActive;
  wire gfxAllowed;
  wire page1Allowed;
  wire cfgHit;
  wire [15:0] cursorAddr;
  wire colPhase;

  // legacy settings count only in emulation with native select clear
  assign legacyActive = emulation_mode_reg[`DMAG_EMU_EN_BIT]
    & ~miscOutput[`DMAG_MISC_NATIVE_BIT];
  assign gfxAllowed = ~legacyActive | legacyCfg[`DMAG_CFG_GFX_EN];
  assign page1Allowed = ~legacyActive | legacyCfg[`DMAG_CFG_PAGE1_EN];
  assign cfgHit = (ioAddr == `DMAG_LEGACY_CFG_ADDR);
  assign cursorAddr = {cursor_loc_high, cursor_loc_low};
  assign colPhase = (state == ST_COL) | (state == ST_DONE);

  // legacy configuration register write
  always @(posedge clock)
  begin
    if (reset)
      legacyCfg <= `DMAG_LEGACY_CFG_RESET;
    else if (ioWrite && cfgHit)
      legacyCfg <= ioWrData;
  end

  // read data: config register, or sequencer index with config bits on top
  always @(posedge clock)
  begin
    if (reset)
      ioRdData <= 8'h00;
    else if (ioRead && cfgHit)
      ioRdData <= legacyCfg;
    else if (ioRead && ioAddr == 16'h03C4)
      ioRdData <= {legacyCfg[`DMAG_CFG_PAGE1_EN], legacyCfg[`DMAG_CFG_GFX_EN],
        seqIndex[5:0]};
    else if (ioRead)
      ioRdData <= 8'h00;
  end

  // page select honoured only when upper page allowed
  always @(posedge clock)
  begin
    if (reset)
      effPageSel <= 1'b0;
    else
      effPageSel <= hostModeCtrl[`DMAG_PAGE_SEL_BIT] & page1Allowed;
  end

  // host window check for locked text, half-memory and full-memory settings
  always @*
  begin
    if (!gfxAllowed)
      hostInWindow = ((hostAddr & `DMAG_WIN_TEXT_MASK) == `DMAG_WIN_TEXT_BASE);
    else if (legacyActive && !page1Allowed)
      hostInWindow = ((hostAddr & `DMAG_WIN_HALF_MASK) == `DMAG_WIN_LOW_BASE);
    else if (legacyActive)
      hostInWindow = ((hostAddr & `DMAG_WIN_FULL_MASK) == `DMAG_WIN_LOW_BASE);
    else
      hostInWindow = 1'b1;
  end

  // host row and column address forming
  always @*
  begin
    if (!chainMode)
      hostRowA = hostAddr[7:0];
    else if (chain_select_code == 2'h0)
      hostRowA = {hostAddr[6:0], hostAddr[16]};
    else
      hostRowA = {hostAddr[6:0], plane_page_bit};
    hostRowB = hostRowA;
    hostCol = {hostAddr[15], hostAddr[8], hostAddr[13], hostAddr[12],
      hostAddr[11], hostAddr[10], hostAddr[9], hostAddr[14]};
  end

  // CRT row and column forming for text and graphics
  always @*
  begin
    crtRowA = display_addr_counter[7:0];
    crtColA = {display_addr_counter[15], display_addr_counter[8],
      display_addr_counter[13], display_addr_counter[12], display_addr_counter[11],
      display_addr_counter[10], display_addr_counter[9], display_addr_counter[14]};
    if (graphicsMode && gfxAllowed)
    begin
      crtRowB = crtRowA;
      crtColB = crtColA;
    end
    else
    begin
      crtRowB = {char_code[2:0], row_scan_count};
      crtColB = {font_select_code[1], char_code[3], 1'b0, char_code[7:4],
        font_select_code[0]};
    end
  end

  // source select for the address buses
  always @*
  begin
    if (src == SRC_REF)
    begin
      selRowA = refreshRow;
      selRowB = refreshRow;
      selColA = 8'h00;
      selColB = 8'h00;
    end
    else if (src == SRC_CRT)
    begin
      selRowA = crtRowA;
      selRowB = crtRowB;
      selColA = crtColA;
      selColB = crtColB;
    end
    else
    begin
      selRowA = hostRowA;
      selRowB = hostRowB;
      selColA = hostCol;
      selColB = hostCol;
    end
  end

  dmag_addr_mux muxBusA
  (
    .rowAddr(selRowA),
    .colAddr(selColA),
    .colPhase(colPhase),
    .busOut(muxA)
  );

  dmag_addr_mux muxBusB
  (
    .rowAddr(selRowB),
    .colAddr(selColB),
    .colPhase(colPhase),
    .busOut(muxB)
  );

  // DRAM cycle sequencer: refresh in blanking, then CRT, then host
  always @(posedge clock)
  begin
    if (reset)
    begin
      state <= ST_IDLE;
      src <= SRC_HOST;
      refreshDone <= 3'h0;
      refreshRow <= 8'h00;
      crtPending <= 1'b0;
      hostAck <= 1'b0;
      hostRefused <= 1'b0;
      rowStrobe_n <= 1'b1;
      colStrobe_n <= 1'b1;
      mem_bus_a <= 8'h00;
      mem_bus_b <= 8'h00;
    end
    else
    begin
      hostAck <= 1'b0;
      hostRefused <= 1'b0;
      mem_bus_a <= muxA;
      mem_bus_b <= muxB;
      if (charClk && !hBlank)
        crtPending <= 1'b1;
      if (lineStart)
        refreshDone <= 3'h0;
      case (state)
        ST_IDLE:
        begin
          rowStrobe_n <= 1'b1;
          colStrobe_n <= 1'b1;
          if (hBlank && refreshDone != `DMAG_REFRESH_PER_LINE)
          begin
            src <= SRC_REF;
            state <= ST_ROW;
          end
          else if (crtPending && !hBlank)
          begin
            src <= SRC_CRT;
            crtPending <= 1'b0;
            state <= ST_ROW;
          end
          else if (hostReq && !hostInWindow)
            hostRefused <= 1'b1;
          else if (hostReq)
          begin
            src <= SRC_HOST;
            state <= ST_ROW;
          end
        end
        ST_ROW:
        begin
          rowStrobe_n <= 1'b0;
          state <= ST_COL;
        end
        ST_COL:
        begin
          colStrobe_n <= (src == SRC_REF); // refresh is row-only read
          state <= ST_DONE;
        end
        ST_DONE:
        begin
          rowStrobe_n <= 1'b1;
          colStrobe_n <= 1'b1;
          state <= ST_IDLE;
          if (src == SRC_REF)
          begin
            refreshRow <= refreshRow + 8'h01;
            refreshDone <= refreshDone + 3'h1;
          end
          if (src == SRC_HOST)
            hostAck <= 1'b1;
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // display address counter, split screen and row scan
  always @(posedge clock)
  begin
    if (reset)
    begin
      display_addr_counter <= 16'h0000;
      rowBase <= 16'h0000;
      row_scan_count <= 5'h00;
    end
    else if (screenStart)
    begin
      display_addr_counter <= startAddr;
      rowBase <= startAddr;
      row_scan_count <= (graphicsMode && gfxAllowed) ? 5'h00 : preset_row_scan_reg;
    end
    else if (lineStart && scanLine == line_compare_reg)
    begin
      display_addr_counter <= 16'h0000;
      rowBase <= 16'h0000;
      row_scan_count <= 5'h00;
    end
    else if (lineStart)
    begin
      if (row_scan_count == max_scan_line_reg)
      begin
        row_scan_count <= 5'h00;
        rowBase <= rowBase + {7'h00, row_offset_reg, 1'b0};
        display_addr_counter <= rowBase + {7'h00, row_offset_reg, 1'b0};
      end
      else
      begin
        row_scan_count <= row_scan_count + 5'h01;
        display_addr_counter <= rowBase;
      end
    end
    else if (state == ST_DONE && src == SRC_CRT)
      display_addr_counter <= display_addr_counter + 16'h0001;
  end

  // cursor match on address and scan line range
  always @(posedge clock)
  begin
    if (reset)
      cursorActive <= 1'b0;
    else
      cursorActive <= (display_addr_counter == cursorAddr)
        && (row_scan_count >= cursor_start_reg)
        && (row_scan_count <= cursor_end_reg) && !hBlank;
  end

  // vertical display end interrupt, held until cleared; set wins
  always @(posedge clock)
  begin
    if (reset)
      crt_interrupt_out <= 1'b0;
    else
    begin
      // set in the cycle after the end-of-display line start
      if (lineStart && scanLine == vert_display_end_reg
        && !vert_retrace_end_reg[`DMAG_VRE_DIS_BIT])
        crt_interrupt_out <= 1'b1;
      else if (!vert_retrace_end_reg[`DMAG_VRE_CLR_BIT])
        crt_interrupt_out <= 1'b0;
    end
  end
endmodule // dmag_display_memory_address_gen

//--- rtl/dmag_regs.vh
// register offsets, field positions, reset values and timing counts for the address generator
`ifndef DMAG_REGS_VH
`define DMAG_REGS_VH
`define DMAG_LEGACY_CFG_ADDR 16'h03BF
`define DMAG_LEGACY_CFG_RESET 8'h00
`define DMAG_CFG_GFX_EN 0
`define DMAG_CFG_PAGE1_EN 1
`define DMAG_EMU_EN_BIT 2
`define DMAG_MISC_NATIVE_BIT 0
`define DMAG_PAGE_SEL_BIT 7
`define DMAG_VRE_CLR_BIT 4
`define DMAG_VRE_DIS_BIT 5
`define DMAG_SEQ_IDX_CFG0 6
`define DMAG_SEQ_IDX_CFG1 7
`define DMAG_REFRESH_PER_LINE 3'h6
`define DMAG_WIN_TEXT_MASK 20'hFF000
`define DMAG_WIN_TEXT_BASE 20'hB0000
`define DMAG_WIN_HALF_MASK 20'hF8000
`define DMAG_WIN_FULL_MASK 20'hF0000
`define DMAG_WIN_LOW_BASE 20'hB0000
`endif

//--- test/dmag_display_memory_address_gen_props.sv
// port assertions for the address generator
`timescale 1ns/1ps
module dmag_props (
  input wire clock,
  input wire reset,
  input wire hostAck,
  input wire rowStrobe_n,
  input wire colStrobe_n,
  input wire hBlank,
  input wire lineStart,
  input wire [9:0] scanLine,
  input wire [9:0] vert_display_end_reg,
  input wire [7:0] vert_retrace_end_reg,
  input wire crt_interrupt_out,
  input wire [7:0] refreshRow
);
  default clocking dc @(posedge clock); endclocking
  default disable iff (reset);
  reg [7:0] prevRow;
  reg [3:0] refCnt;
  reg [3:0] idle;
  // refresh steps since line start, cycles since blanking
  always @(posedge clock)
  begin
    prevRow <= refreshRow;
    idle <= hBlank ? 4'h0 : idle + {3'h0, idle != 4'hF};
    if (reset || lineStart)
      refCnt <= 4'h0;
    else if (refreshRow != prevRow)
      refCnt <= refCnt + 4'h1;
  end
  chk_ack_after_col: assert property (hostAck |-> !$past(colStrobe_n))
    else $error("ack without column strobe");
  chk_col_after_row: assert property ($fell(colStrobe_n) |-> !rowStrobe_n)
    else $error("column strobe without row strobe");
  chk_refresh_step: assert property (refreshRow != prevRow |-> refreshRow == prevRow + 8'h01)
    else $error("refresh row skipped");
  chk_refresh_blank: assert property (refreshRow != prevRow |-> idle < 4'h7)
    else $error("refresh outside blanking");
  chk_six_refresh: assert property (refCnt <= 4'h6)
    else $error("too many refreshes in a line");
  chk_irq_set: assert property (lineStart && scanLine == vert_display_end_reg
    && !vert_retrace_end_reg[5] |=> crt_interrupt_out)
    else $error("interrupt not raised");
  chk_irq_hold: assert property (crt_interrupt_out && vert_retrace_end_reg[4] |=> crt_interrupt_out)
    else $error("interrupt dropped");
  chk_irq_cause: assert property ($rose(crt_interrupt_out) |-> $past(lineStart))
    else $error("interrupt without line start");
endmodule // dmag_props
bind dmag_display_memory_address_gen dmag_props chk (.*);

//--- test/dmag_display_memory_address_gen_tb.sv
// self-checking bench for the address generator
`timescale 1ns/1ps
`define CHK(a, b) begin samplesChecked++; if ((a) !== (b)) begin errors++; $display("[ERR] %0t %h %h", $time, a, b); end end
module dmag_display_memory_address_gen_tb;
  logic clock = 0, reset = 1, ioWrite = 0, ioRead = 0, hostReq = 0, chainMode = 0;
  logic plane_page_bit = 0, graphicsMode = 1, charClk = 0, hBlank = 0, screenStart = 0;
  logic lineStart = 0, hostAck, hostRefused, rowStrobe_n, colStrobe_n, cursorActive;
  logic crt_interrupt_out, effPageSel;
  logic [15:0] ioAddr = 0, startAddr = 0, display_addr_counter, rowLatch, colLatch;
  logic [7:0] ioWrData = 0, emulation_mode_reg = 0, miscOutput = 0, seqIndex = 0;
  logic [7:0] hostModeCtrl = 0, char_code = 0, row_offset_reg, cursor_loc_high, cursor_loc_low;
  logic [7:0] vert_retrace_end_reg = 8'h10, ioRdData, mem_bus_a, mem_bus_b, refreshRow, colCount;
  logic [7:0] c, r0 = 0;
  logic [19:0] hostAddr = 0;
  logic [1:0] chain_select_code = 0, font_select_code = 0, ok;
  logic [9:0] scanLine = 0, line_compare_reg = 10'h3FF, vert_display_end_reg = 10'h15E;
  logic [4:0] preset_row_scan_reg = 0, max_scan_line_reg, cursor_start_reg, cursor_end_reg;
  logic [4:0] row_scan_count;
  integer seed = 32'h70CB7D15;
  int errors = 0, samplesChecked = 0, cyc = 0;
  dmag_display_memory_address_gen dut (.*);
  dmag_dram_model dram (.*);
  initial
  begin
    forever #4 clock = ~clock;
  end
  // column order shared by host and display fetches
  function [7:0] colOf(input [15:0] x);
    colOf = {x[15], x[8], x[13:9], x[14]};
  endfunction
  task step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task ioW(input [15:0] ad, input [7:0] d);
    ioAddr = ad;
    ioWrData = d;
    ioWrite = 1;
    step(1);
    ioWrite = 0;
  endtask
  task ioR(input [15:0] ad, output [7:0] d);
    ioAddr = ad;
    ioRead = 1;
    step(1);
    ioRead = 0;
    d = ioRdData;
  endtask
  // one host request held until acknowledged or refused, or for at most 20 cycles
  task host(input [19:0] ad, output [1:0] res);
    int n;
    hostAddr = ad;
    hostReq = 1;
    n = 0;
    do step(1); while (hostAck !== 1 && hostRefused !== 1 && ++n < 20);
    res = {hostAck, hostRefused};
    hostReq = 0;
    step(1);
  endtask
  task pulseLs;
    lineStart = 1;
    step(1);
    lineStart = 0;
    step(2);
  endtask
  task results;
    if (errors == 0 && samplesChecked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      errors++;
      results;
    end
  end
  initial
  begin
    {cursor_loc_high, cursor_loc_low, row_offset_reg} = $random(seed);
    {cursor_start_reg, cursor_end_reg, max_scan_line_reg} = $random(seed);
    repeat (6) @(posedge clock);
    #1 reset = 0;
    // random host cycles, legacy window off, all chain codes
    for (int i = 0; i < 20; i++)
    begin
      hostAddr = $random(seed);
      chainMode = i > 3;
      chain_select_code = i[1:0];
      plane_page_bit = $random(seed);
      host(hostAddr, ok);
      c = chainMode ? {hostAddr[6:0], chain_select_code == 0 ? hostAddr[16] : plane_page_bit}
        : hostAddr[7:0];
      `CHK(ok, 2'b10)
      `CHK(rowLatch, {c, c})
      `CHK(colLatch, {colOf(hostAddr[15:0]), colOf(hostAddr[15:0])})
    end
    // legacy windows by configuration
    emulation_mode_reg = 8'h04;
    hostModeCtrl = 8'h80;
    ioW(16'h03BF, 8'h00);
    host(20'hB1000, ok);
    `CHK(ok, 2'b01)
    host(20'hB0800, ok);
    `CHK(ok, 2'b10)
    ioW(16'h03BF, 8'h01);
    host(20'hB8000, ok);
    `CHK({ok, effPageSel}, 3'b010)
    ioW(16'h03BF, 8'h03);
    host(20'hB8000, ok);
    `CHK({ok, effPageSel}, 3'b101)
    seqIndex = $random(seed);
    ioR(16'h03C4, c);
    `CHK(c, {2'b11, seqIndex[5:0]})
    ioW(16'h03BF, 8'h00);
    miscOutput = 8'h01;
    host(20'hB8000, ok);
    `CHK(ok, 2'b10)
    // blanking long enough for six refreshes
    repeat (2)
    begin
      hBlank = 1;
      pulseLs;
      step(40);
      hBlank = 0;
      step(2);
      r0 = r0 + 8'h06;
      `CHK(refreshRow, r0)
    end
    scanLine = vert_display_end_reg;
    pulseLs;
    `CHK(crt_interrupt_out, 1'b1)
    step(6);
    `CHK(crt_interrupt_out, 1'b1)
    vert_retrace_end_reg = 8'h00;
    step(2);
    `CHK(crt_interrupt_out, 1'b0)
    vert_retrace_end_reg = 8'h30;
    pulseLs;
    `CHK(crt_interrupt_out, 1'b0)
    // text screen start, scrolled by three scan lines
    scanLine = 10'h000;
    startAddr = $random(seed);
    graphicsMode = 0;
    preset_row_scan_reg = 5'h03;
    {cursor_loc_high, cursor_loc_low} = startAddr;
    cursor_start_reg = 5'h02;
    cursor_end_reg = 5'h04;
    screenStart = 1;
    step(1);
    screenStart = 0;
    step(2);
    `CHK(display_addr_counter, startAddr)
    `CHK(row_scan_count, 5'h03)
    `CHK(cursorActive, 1'b1)
    char_code = $random(seed);
    font_select_code = $random(seed);
    c = colCount;
    charClk = 1;
    step(1);
    charClk = 0;
    for (int n = 0; n < 20 && colCount == c; n++) step(1);
    `CHK(rowLatch[7:0], {char_code[2:0], 5'h03})
    `CHK(colLatch[7:0], {font_select_code[1], char_code[3], 1'b0, char_code[7:4],
      font_select_code[0]})
    `CHK(rowLatch[15:8], startAddr[7:0])
    `CHK(colLatch[15:8], colOf(startAddr))
    line_compare_reg = 10'h0C8;
    scanLine = 10'h0C8;
    pulseLs;
    `CHK(display_addr_counter, 16'h0000)
    preset_row_scan_reg = 5'h00; // preset back to zero; graphics ignores preset and starts row scan at zero
    results;
  end
endmodule // dmag_display_memory_address_gen_tb

//--- test/dmag_dram_model.sv
// behavioural display dram that latches row and column from the multiplexed buses
`timescale 1ns/1ps
module dmag_dram_model (
  input wire clock,
  input wire rowStrobe_n,
  input wire colStrobe_n,
  input wire [7:0] mem_bus_a,
  input wire [7:0] mem_bus_b,
  output reg [15:0] rowLatch,
  output reg [15:0] colLatch,
  output reg [7:0] colCount = 8'h00
);
  reg rPrev = 1'b1;
  reg cPrev = 1'b1;
  // address taken on the falling strobe, as a dram does
  always @(posedge clock)
  begin
    if (!rowStrobe_n && rPrev)
      rowLatch <= {mem_bus_a, mem_bus_b};
    if (!colStrobe_n && cPrev)
    begin
      colLatch <= {mem_bus_a, mem_bus_b};
      colCount <= colCount + 8'h01;
    end
    rPrev <= rowStrobe_n;
    cPrev <= colStrobe_n;
  end
endmodule // dmag_dram_model
